// ===== pkg/vll_pkg.sv
/*
  Constants, register map and shared helpers of the line-locked resampler.
  Assumes a single pclk domain; every other rate is an enable pulse.
*/
// Contract
// - Sample on fixed clock; line length varies
// - Divide external 8x reference by two internally
// - Filter, decimate; line locking at single rate
// - Nominal line: 910 or 1135 samples
// - Square pixel: 780 or 944 per line
// - Interpolate surplus samples down to pixel count
// - Requested pixels never exceed available samples
// - Line reset edges accurate to one pixel
// - Accept 525/60 and 625/50 composite formats
// - Three-bit format code at index 0x01
package vll_pkg;
  localparam int SMP_W = 8;
  localparam int LEN_W = 11;
  localparam int PIX_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_FORMAT = 10'h001;
  localparam logic [9:0] IDX_HRATIO = 10'h002;
  localparam logic [9:0] IDX_ADLY = 10'h003;
  localparam logic [9:0] IDX_BDLY = 10'h004;
  localparam logic [9:0] IDX_HDLY = 10'h005;
  localparam logic [9:0] IDX_VDLY = 10'h006;
  localparam logic [9:0] IDX_VACT = 10'h007;
  localparam logic [9:0] IDX_CROP = 10'h008;
  localparam logic [9:0] IDX_HACT = 10'h009;
  localparam logic [9:0] IDX_CTRL = 10'h00A;
  localparam logic [9:0] IDX_STATUS = 10'h00B;

  // Field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_SQ = 1;
  localparam int ST_OVR = 16;

  // Values after reset
  localparam logic [7:0] FMT_RST = 8'h01;
  localparam logic [7:0] CROP_RST = 8'h03;
  localparam logic [7:0] HACT_RST = 8'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // Format codes
  localparam logic [2:0] FMT_NTSC_M = 3'h1;
  localparam logic [2:0] FMT_NTSC_J = 3'h2;
  localparam logic [2:0] FMT_PAL_BDGHI = 3'h3;
  localparam logic [2:0] FMT_PAL_M = 3'h4;
  localparam logic [2:0] FMT_PAL_N = 3'h5;
  localparam logic [2:0] FMT_SECAM = 3'h6;
  localparam logic [2:0] FMT_PAL_NC = 3'h7;

  // Line lengths in single-rate samples (910, 1135) and pixels (780, 944)
  localparam logic [10:0] NOM_525 = 11'h38E;
  localparam logic [10:0] NOM_625 = 11'h46F;
  localparam logic [9:0] SQ_525 = 10'h30C;
  localparam logic [9:0] SQ_625 = 10'h3B0;

  // Counts of single-rate ticks
  localparam logic [3:0] LRST_TICKS = 4'h8;
  localparam logic [10:0] LOCK_TOL = 11'h010;

  function automatic logic vll_is_525(input logic [2:0] f);
    return (f == FMT_NTSC_M) || (f == FMT_NTSC_J) || (f == FMT_PAL_M);
  endfunction
endpackage

// ===== pkg/vll_pix_if.sv
/*
  Pixel stream carrier with valid and ready between resampler parts.
  Assumes both ends run on pclk.
*/
`timescale 1ns/100ps
interface vll_pix_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ===== design/vll_buf.sv
/*
  Two-entry pixel buffer with valid and ready on both sides.
  Assumes the drain may stall at will; fill sees ready low when full.
*/
`timescale 1ns/100ps
module vll_buf (
  input wire logic pclk,
  input wire logic presetn,
  vll_pix_if.snk fill,
  vll_pix_if.src drain
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } vll_buf_state_t;

  vll_buf_state_t st_ff, nxt_st;
  logic push, pop;

  assign fill.ready = (st_ff.cnt != 2'h2);
  assign drain.valid = (st_ff.cnt != 2'h0);
  assign drain.data = st_ff.mem[st_ff.rp];

  always_comb begin
    nxt_st = st_ff;
    push = fill.valid & fill.ready;
    pop = drain.valid & drain.ready;
    if (push) begin
      nxt_st.mem[st_ff.wp] = fill.data;
      nxt_st.wp = ~st_ff.wp;
    end
    if (pop) begin
      nxt_st.rp = ~st_ff.rp;
    end
    case ({push, pop})
      2'b10: nxt_st.cnt = st_ff.cnt + 2'h1;
      2'b01: nxt_st.cnt = st_ff.cnt - 2'h1;
      default: nxt_st.cnt = st_ff.cnt;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  AST_BUF_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.cnt == 2'h2) |-> !fill.ready)
    else $error("buffer full but still ready");
  AST_BUF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (drain.valid && !drain.ready) |=> (drain.valid && $stable(drain.data)))
    else $error("stalled pixel changed or vanished");
endmodule

// ===== design/vll_resampler.sv
/*
  Line-locked resampler: fixed-clock sampling, decimation, line length
  measurement, phase interpolation to a programmed pixel count, APB regs.
  Assumes the 8x subcarrier reference, video samples and sync arrive as
  pins from outside pclk; the reference must stay below pclk/4.
*/
`timescale 1ns/100ps
module vll_resampler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_clk_in,
  input wire logic [7:0] video_sample,
  input wire logic hsync_n,
  output logic line_reset_output_n,
  output logic line_start,
  output logic [7:0] pix_data,
  output logic pix_valid,
  input wire logic pix_ready
);
  typedef enum logic [1:0] {
    VLL_IDLE, VLL_DELAY, VLL_ACTIVE, VLL_FLUSH
  } vll_seq_t;

  typedef struct packed {
    logic [1:0] ref_sy;
    logic ref_d;
    logic [1:0] hs_sy;
    logic [7:0] v_sy0;
    logic [7:0] v_sy1;
    logic dbl_en;
    logic div;
    logic sgl_en;
    logic [7:0] s_new;
    logic [7:0] s_old;
    logic [7:0] cur;
    logic [7:0] prev;
    logic hs_prev;
    vll_seq_t seq;
    logic seen;
    logic [10:0] cnt;
    logic [10:0] len;
    logic [10:0] acc;
    logic [9:0] pix;
    logic [7:0] dly;
    logic [3:0] lrst;
    logic lrstn;
    logic lstart;
    logic emit;
    logic [7:0] pdata;
    logic ovr;
    logic [7:0] fmt;
    logic [15:0] hratio;
    logic [7:0] adly;
    logic [7:0] bdly;
    logic [7:0] hdly;
    logic [7:0] vdly;
    logic [7:0] vact;
    logic [7:0] crop;
    logic [7:0] hact;
    logic [1:0] ctrl;
    logic [31:0] prdata;
    logic slverr;
  } vll_state_t;

  vll_state_t st_ff, nxt_st;
  logic edge_det, tick, new_emit, hold, set_ovr, clr_ovr;
  logic rd_en, wr_en, locked, is525;
  logic [10:0] nom, eff_len, acc_rem, dec;
  logic [11:0] acc_sum;
  logic [9:0] dsr, dsd;
  logic [4:0] ph;
  logic [7:0] pix_val;

  vll_pix_if fill_if ();
  vll_pix_if out_if ();

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [10:0] vll_dec(input logic [11:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a[11:2] >= vll_pkg::IDX_FORMAT) &&
         (a[11:2] <= vll_pkg::IDX_STATUS);
    return {ok, a[11:2]};
  endfunction

  // Two-tap blend; weight ph on a, 32 - ph on b
  function automatic logic [7:0] vll_mix(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [4:0] w);
    logic [12:0] sum;
    sum = ({5'h00, a} * {8'h00, w}) +
          ({5'h00, b} * (13'h0020 - {8'h00, w}));
    return sum[12:5];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    // Pin synchronisers; stage one feeds only stage two
    nxt_st.ref_sy = {st_ff.ref_sy[0], ref_clk_in};
    nxt_st.ref_d = st_ff.ref_sy[1];
    nxt_st.hs_sy = {st_ff.hs_sy[0], hsync_n};
    nxt_st.v_sy0 = video_sample;
    nxt_st.v_sy1 = st_ff.v_sy0;
    // Reference edge gives the double rate; every second one the single
    nxt_st.dbl_en = st_ff.ref_sy[1] & ~st_ff.ref_d;
    nxt_st.div = st_ff.div ^ st_ff.dbl_en;
    nxt_st.sgl_en = st_ff.dbl_en & st_ff.div;
    if (st_ff.dbl_en) begin
      nxt_st.s_new = st_ff.v_sy1;
      nxt_st.s_old = st_ff.s_new;
    end
    if (st_ff.sgl_en) begin
      // Pair average is the low-pass, keeping one of two is the decimation
      nxt_st.cur = 8'(({1'b0, st_ff.s_new} + {1'b0, st_ff.s_old}) >> 1);
      nxt_st.prev = st_ff.cur;
      nxt_st.hs_prev = st_ff.hs_sy[1];
    end
    tick = st_ff.sgl_en & st_ff.ctrl[vll_pkg::CTRL_EN];
    edge_det = tick & st_ff.hs_prev & ~st_ff.hs_sy[1];

    is525 = vll_pkg::vll_is_525(st_ff.fmt[2:0]);
    nom = is525 ? vll_pkg::NOM_525 : vll_pkg::NOM_625;
    locked = st_ff.seen &&
      (({1'b0, st_ff.len} + {1'b0, vll_pkg::LOCK_TOL}) >= {1'b0, nom}) &&
      ({1'b0, st_ff.len} <= ({1'b0, nom} + {1'b0, vll_pkg::LOCK_TOL}));
    eff_len = (st_ff.len > {3'h0, st_ff.adly}) ?
      st_ff.len - {3'h0, st_ff.adly} : 11'h001;
    // Square mode cannot serve PAL-N combination; it uses the crop width
    if (st_ff.ctrl[vll_pkg::CTRL_SQ] &&
        st_ff.fmt[2:0] != vll_pkg::FMT_PAL_NC) begin
      dsr = is525 ? vll_pkg::SQ_525 : vll_pkg::SQ_625;
    end else begin
      dsr = {st_ff.crop[1:0], st_ff.hact};
    end
    // A request beyond the measured line less adly is cut to that usable length
    dsd = ({1'b0, dsr} > eff_len) ? eff_len[9:0] : dsr;
    acc_sum = {1'b0, st_ff.acc} + {2'h0, dsd};
    acc_rem = 11'(acc_sum - {1'b0, eff_len});

    ////////////////////////////////////////////////////////////////////////
    // Line timing
    nxt_st.lstart = 1'b0;
    if (edge_det) begin
      nxt_st.lstart = 1'b1;
      nxt_st.lrst = vll_pkg::LRST_TICKS;
      nxt_st.cnt = 11'h000;
      if (st_ff.seen && st_ff.cnt != 11'h7FF) begin
        nxt_st.len = 11'(st_ff.cnt + 11'h001);
      end
      nxt_st.seen = 1'b1;
    end else if (tick) begin
      if (st_ff.cnt != 11'h7FF) begin
        nxt_st.cnt = 11'(st_ff.cnt + 11'h001);
      end
      if (st_ff.lrst != 4'h0) begin
        nxt_st.lrst = st_ff.lrst - 4'h1;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Resampling sequencer; it accumulates the pixel count per sample and
    // emits a pixel whenever the sum passes the usable line length
    new_emit = 1'b0;
    ph = 5'h00;
    if (!st_ff.ctrl[vll_pkg::CTRL_EN]) begin
      nxt_st.seq = VLL_IDLE;
      nxt_st.seen = 1'b0;
    end else if (tick) begin
      case (st_ff.seq)
        VLL_IDLE: begin
          if (edge_det) begin
            nxt_st.seq = VLL_DELAY;
            nxt_st.dly = 8'h00;
          end
        end
        VLL_DELAY: begin
          if (edge_det) begin
            nxt_st.dly = 8'h00;
          end else if (st_ff.dly == st_ff.adly) begin
            nxt_st.seq = VLL_ACTIVE;
            nxt_st.acc = 11'h000;
            nxt_st.pix = 10'h000;
          end else begin
            nxt_st.dly = st_ff.dly + 8'h01;
          end
        end
        VLL_ACTIVE: begin
          if (edge_det) begin
            nxt_st.seq = (st_ff.pix < dsd) ? VLL_FLUSH : VLL_DELAY;
            nxt_st.dly = 8'h00;
          end else if (st_ff.pix < dsd) begin
            if (acc_sum >= {1'b0, eff_len}) begin
              new_emit = 1'b1;
              nxt_st.acc = acc_rem;
              // Phase scaled to 1024, not to the pixel count: a coarse
              // approximation that avoids a divider
              ph = acc_rem[9:5];
            end else begin
              nxt_st.acc = acc_sum[10:0];
            end
          end
        end
        VLL_FLUSH: begin
          // Short line: pad with the newest sample so the count holds
          if (st_ff.pix < dsd) begin
            new_emit = 1'b1;
          end
          if (st_ff.pix + 10'h001 >= dsd) begin
            nxt_st.seq = VLL_DELAY;
            nxt_st.dly = 8'h00;
          end
        end
        default: nxt_st.seq = VLL_IDLE;
      endcase
    end
    if (!nxt_st.seen) begin
      nxt_st.len = nom;
    end
    nxt_st.lrstn = (nxt_st.lrst == 4'h0);

    ////////////////////////////////////////////////////////////////////////
    // Hand-off; a live source cannot wait, so a pixel that meets a stalled
    // one is dropped and flagged, but the line count still advances
    pix_val = vll_mix(st_ff.prev, st_ff.cur, ph);
    hold = st_ff.emit & ~fill_if.ready;
    nxt_st.emit = hold;
    set_ovr = new_emit & hold;
    if (new_emit) begin
      nxt_st.pix = 10'(st_ff.pix + 10'h001);
      if (!hold) begin
        nxt_st.emit = 1'b1;
        nxt_st.pdata = pix_val;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait; read data and error latched in the setup cycle
    dec = vll_dec(paddr);
    rd_en = psel & ~penable;
    wr_en = psel & penable & pwrite & dec[10];
    if (rd_en) begin
      nxt_st.slverr = ~dec[10];
      nxt_st.prdata = 32'h0000_0000;
      if (!dec[10]) begin
        nxt_st.prdata = 32'h0000_0000;
      end else if (dec[9:0] == vll_pkg::IDX_FORMAT) begin
        nxt_st.prdata = {24'h00_0000, st_ff.fmt};
      end else if (dec[9:0] == vll_pkg::IDX_HRATIO) begin
        nxt_st.prdata = {16'h0000, st_ff.hratio};
      end else if (dec[9:0] == vll_pkg::IDX_ADLY) begin
        nxt_st.prdata = {24'h00_0000, st_ff.adly};
      end else if (dec[9:0] == vll_pkg::IDX_BDLY) begin
        nxt_st.prdata = {24'h00_0000, st_ff.bdly};
      end else if (dec[9:0] == vll_pkg::IDX_HDLY) begin
        nxt_st.prdata = {24'h00_0000, st_ff.hdly};
      end else if (dec[9:0] == vll_pkg::IDX_VDLY) begin
        nxt_st.prdata = {24'h00_0000, st_ff.vdly};
      end else if (dec[9:0] == vll_pkg::IDX_VACT) begin
        nxt_st.prdata = {24'h00_0000, st_ff.vact};
      end else if (dec[9:0] == vll_pkg::IDX_CROP) begin
        nxt_st.prdata = {24'h00_0000, st_ff.crop};
      end else if (dec[9:0] == vll_pkg::IDX_HACT) begin
        nxt_st.prdata = {24'h00_0000, st_ff.hact};
      end else if (dec[9:0] == vll_pkg::IDX_CTRL) begin
        nxt_st.prdata = {30'h0000_0000, st_ff.ctrl};
      end else begin
        nxt_st.prdata = {13'h0000, is525, locked, st_ff.ovr, 5'h00,
                         st_ff.len};
      end
    end
    clr_ovr = 1'b0;
    if (wr_en) begin
      if (dec[9:0] == vll_pkg::IDX_FORMAT) begin
        nxt_st.fmt = pwdata[7:0];
      end else if (dec[9:0] == vll_pkg::IDX_HRATIO) begin
        nxt_st.hratio = pwdata[15:0];
      end else if (dec[9:0] == vll_pkg::IDX_ADLY) begin
        nxt_st.adly = pwdata[7:0];
      end else if (dec[9:0] == vll_pkg::IDX_BDLY) begin
        nxt_st.bdly = pwdata[7:0];
      end else if (dec[9:0] == vll_pkg::IDX_HDLY) begin
        nxt_st.hdly = pwdata[7:0];
      end else if (dec[9:0] == vll_pkg::IDX_VDLY) begin
        nxt_st.vdly = pwdata[7:0];
      end else if (dec[9:0] == vll_pkg::IDX_VACT) begin
        nxt_st.vact = pwdata[7:0];
      end else if (dec[9:0] == vll_pkg::IDX_CROP) begin
        nxt_st.crop = pwdata[7:0];
      end else if (dec[9:0] == vll_pkg::IDX_HACT) begin
        nxt_st.hact = pwdata[7:0];
      end else if (dec[9:0] == vll_pkg::IDX_CTRL) begin
        nxt_st.ctrl = pwdata[1:0];
      end else begin
        clr_ovr = pwdata[vll_pkg::ST_OVR];
      end
    end
    // Set beats clear when both land together
    nxt_st.ovr = (st_ff.ovr & ~clr_ovr) | set_ovr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.lrstn <= 1'b1;
      st_ff.len <= vll_pkg::NOM_525;
      st_ff.fmt <= vll_pkg::FMT_RST;
      st_ff.crop <= vll_pkg::CROP_RST;
      st_ff.hact <= vll_pkg::HACT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign fill_if.valid = st_ff.emit;
  assign fill_if.data = st_ff.pdata;
  assign out_if.ready = pix_ready;
  assign pix_data = out_if.data;
  assign pix_valid = out_if.valid;
  assign pready = 1'b1;
  assign prdata = st_ff.prdata;
  assign pslverr = st_ff.slverr;
  assign line_reset_output_n = st_ff.lrstn;
  assign line_start = st_ff.lstart;

  vll_buf u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .fill(fill_if),
    .drain(out_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  AST_SGL_AFTER_DBL: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.sgl_en |-> ($past(st_ff.dbl_en) && !$past(st_ff.sgl_en)))
    else $error("single-rate tick without double-rate tick");
  AST_EMIT_ON_TICK: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.emit && !$past(st_ff.emit)) |-> $past(st_ff.sgl_en))
    else $error("pixel emitted off the single-rate tick");
  AST_LEN_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_det && st_ff.seen && st_ff.cnt != 11'h7FF && nxt_st.seen) |=>
    (st_ff.len == $past(st_ff.cnt) + 11'h001))
    else $error("line length not captured at sync");
  AST_NOMINAL: assert property (@(posedge pclk) disable iff (!presetn)
    !st_ff.seen |-> (st_ff.len == $past(nom)))
    else $error("unlocked length is not nominal");
  AST_PIX_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
    new_emit |-> (st_ff.pix < dsd))
    else $error("more pixels than requested in a line");
  AST_FLUSH: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && st_ff.seq == VLL_FLUSH && st_ff.pix < dsd) |=>
    (st_ff.pix == $past(st_ff.pix) + 10'h001))
    else $error("flush did not add a pixel");
  AST_CLAMP: assert property (@(posedge pclk) disable iff (!presetn)
    ({1'b0, dsd} <= eff_len))
    else $error("pixel request exceeds usable line");
  AST_LRST: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_det && st_ff.ctrl[vll_pkg::CTRL_EN]) |=> !line_reset_output_n [*3])
    else $error("line reset not low after sync");
  AST_LSTART: assert property (@(posedge pclk) disable iff (!presetn)
    edge_det |=> (line_start ##1 !line_start))
    else $error("line start marker not one cycle");
  AST_FMT_RD: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && dec == {1'b1, vll_pkg::IDX_FORMAT}) |=>
    (prdata == {24'h00_0000, $past(st_ff.fmt)}))
    else $error("format register read mismatch");
endmodule

// ===== test/vll_video_src.sv
/*
  Digitised video source: free-running 8x reference, sample ramp and
  horizontal sync. Assumes the reference stays below pclk/4.
*/
`timescale 1ns/100ps
module vll_video_src #(
  parameter realtime REF_HALF = 10.0,
  parameter int SYNC_TICKS = 20
) (
  output logic ref_clk_in,
  output logic [7:0] video_sample,
  output logic hsync_n,
  input wire logic [10:0] line_len
);
  int edge_cnt = 0;
  int cur_len = 910;
  initial begin
    ref_clk_in = 1'b0;
    video_sample = 8'h00;
    hsync_n = 1'b1;
    // Offset keeps reference edges off the pclk edges, avoiding a race
    #1.0;
    forever #(REF_HALF) ref_clk_in = ~ref_clk_in;
  end
  // Two reference edges per tick; a new length only at a line boundary
  always @(posedge ref_clk_in) begin
    video_sample <= video_sample + 8'h07;
    if (edge_cnt + 1 >= 2 * cur_len) begin
      edge_cnt <= 0;
      cur_len <= line_len;
    end else begin
      edge_cnt <= edge_cnt + 1;
    end
    hsync_n <= !(edge_cnt < 2 * SYNC_TICKS);
  end
endmodule

// ===== test/test_video_line_lock_resampler.sv
/*
  Bench of the line-locked resampler: APB registers, pixels per line,
  line reset timing, buffer stall and overrun.
  Assumes the source model above and a 250 MHz pclk.
*/
`timescale 1ns/100ps
module test_video_line_lock_resampler;
  logic pclk, presetn, psel, penable, pwrite, pix_ready, pready, pslverr;
  logic ref_clk_in, hsync_n, line_reset_output_n, line_start, pix_valid;
  logic err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] video_sample, pix_data, held;
  logic [10:0] vid_len;
  logic [11:0] bad [3] = '{12'h000, 12'h030, 12'h005};
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_ls = 0;
  int hold = 0;
  int pix_cnt = 0;
  int t_fall = 0;
  bit watch = 0;
  bit last_ok = 0;
  bit sink_stop = 0;
  int counts[$];

  vll_resampler dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ref_clk_in, .video_sample,
    .hsync_n, .line_reset_output_n, .line_start, .pix_data, .pix_valid,
    .pix_ready);
  vll_video_src src (.ref_clk_in, .video_sample, .hsync_n,
    .line_len(vid_len));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Seen value shown only when outside the tolerance
  task automatic near(input string what, input int exp, input int got,
                      input int tol);
    chk(what, exp, (got >= exp - tol && got <= exp + tol) ? exp : got);
  endtask

  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [11:0] ra(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  // Request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Pixels are binned 60 ticks after each line start, inside the delay
  always @(posedge pclk) begin
    cyc++;
    pix_ready <= !sink_stop && (cyc % 8 != 5);
    if (pix_valid === 1'b1 && pix_ready === 1'b1) pix_cnt++;
    if (line_start === 1'b1) begin
      n_ls++;
      hold = 600;
    end else if (hold > 0) begin
      hold--;
      if (hold == 0) begin
        counts.push_back(pix_cnt);
        pix_cnt = 0;
      end
    end
  end

  always @(posedge pclk) begin
    if (cyc == 100000) begin
      n_errors++;
      conclude();
    end
  end

  always @(negedge line_reset_output_n) begin
    if (watch && last_ok) near("line interval", vid_len * 10, cyc - t_fall, 10);
    last_ok = watch;
    t_fall = cyc;
  end

  always @(posedge line_reset_output_n) begin
    if (watch) near("line reset width", 80, cyc - t_fall, 1);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic run(input logic [2:0] fmt, input logic [31:0] ctrl,
                     input int len, input int nom, input int exp_pix,
                     input int nl, input logic [31:0] adly);
    vid_len = len[10:0];
    apb(1'b1, ra(vll_pkg::IDX_FORMAT), {29'h0, fmt});
    apb(1'b1, ra(vll_pkg::IDX_ADLY), adly);
    apb(1'b1, ra(vll_pkg::IDX_CTRL), ctrl);
    counts.delete();
    n_ls = 0;
    // A fall from an earlier run must not open an interval
    last_ok = 1'b0;
    watch = 1'b1;
    for (int i = 0; i < 40000 && n_ls < nl + 1; i++) @(posedge pclk);
    repeat (610) @(posedge pclk);
    for (int k = 1; k <= nl; k++) chk("pixels per line", exp_pix, counts[k]);
    apb(1'b0, ra(vll_pkg::IDX_STATUS), 32'h0);
    chk("measured length", len, rd & 32'h7FF);
    chk("locked", (len - nom <= 16 && nom - len <= 16), rd[17]);
    watch = 1'b0;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pix_ready = 1'b1;
    vid_len = 11'h38E;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i <= 10; i++) begin
      apb(1'b0, ra(i[9:0]), 32'h0);
      chk("reset value", (i == 1) ? 1 : (i == 8) ? 3 : (i == 9) ? 12 : 0, rd);
    end
    apb(1'b0, ra(vll_pkg::IDX_STATUS), 32'h0);
    chk("nominal length", 32'h38E, rd & 32'h7FF);
    foreach (bad[j]) begin
      apb(1'b0, bad[j], 32'h0);
      chk("unmapped error", 1, err);
      chk("unmapped data", 0, rd);
    end
    apb(1'b1, 12'h009, 32'hFFFF_FFFF);
    for (int i = 2; i <= 7; i++) begin
      apb(1'b0, ra(i[9:0]), 32'h0);
      chk("no stray write", 0, rd);
      apb(1'b1, ra(i[9:0]), 32'hFFFF_FFFF);
      apb(1'b0, ra(i[9:0]), 32'h0);
      chk("storage width", (i == 2) ? 32'hFFFF : 32'hFF, rd);
    end
    for (int f = 1; f <= 7; f++) begin
      apb(1'b1, ra(vll_pkg::IDX_FORMAT), f);
      apb(1'b0, ra(vll_pkg::IDX_FORMAT), 32'h0);
      chk("format code", f, rd & 32'h07);
      apb(1'b0, ra(vll_pkg::IDX_STATUS), 32'h0);
      chk("525 flag", (f == 1 || f == 2 || f == 4), rd[18]);
    end
    run(3'h1, 32'h3, 905, 910, 780, 2, 32'h70);
    apb(1'b1, ra(vll_pkg::IDX_CTRL), 32'h0);
    run(3'h3, 32'h3, 1140, 1135, 944, 1, 32'h7F);
    apb(1'b1, ra(vll_pkg::IDX_CTRL), 32'h0);
    // Combination format asks for fewer than square pixels: 912
    apb(1'b1, ra(vll_pkg::IDX_HACT), 32'h90);
    run(3'h7, 32'h3, 1160, 1135, 912, 1, 32'h7F);
    sink_stop <= 1'b1;
    repeat (1500) @(posedge pclk);
    held = pix_data;
    repeat (20) @(posedge pclk);
    chk("stalled valid", 1, pix_valid);
    chk("stalled data", held, pix_data);
    apb(1'b0, ra(vll_pkg::IDX_STATUS), 32'h0);
    chk("overrun flag", 1, rd[16]);
    apb(1'b1, ra(vll_pkg::IDX_CTRL), 32'h0);
    apb(1'b1, ra(vll_pkg::IDX_STATUS), 32'h0001_0000);
    apb(1'b0, ra(vll_pkg::IDX_STATUS), 32'h0);
    chk("overrun cleared", 0, rd[16]);
    sink_stop <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("drained", 0, pix_valid);
    // Plain mode takes the width from crop high bits and low byte: 768
    apb(1'b1, ra(vll_pkg::IDX_HACT), 32'h00);
    run(3'h1, 32'h1, 905, 910, 768, 1, 32'h70);
    conclude();
  end
endmodule
